/* core/wdog_pkg.sv */
// Constants shared by the windowed watchdog and clock monitor.
package wdog_pkg;

  // ----------------------------------------------------------------
  // Service key register layout
  // ----------------------------------------------------------------
  localparam int unsigned SEL_MSB      = 7;
  localparam int unsigned SEL_LSB      = 6;
  localparam int unsigned KEY_MSB      = 5;
  localparam int unsigned KEY_LSB      = 1;
  localparam int unsigned CM_BIT       = 0;
  localparam logic [4:0]  SVC_KEY      = 5'h0c;
  localparam logic [4:0]  KEY_READ     = 5'h00;
  localparam logic [1:0]  SEL_RESET    = 2'h3;
  localparam logic        CM_RESET     = 1'h1;

  // ----------------------------------------------------------------
  // Window timing, in idle timer clocks
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W        = 17;
  localparam logic [16:0] LOWER_LIMIT  = 17'h00800;
  localparam logic [16:0] UPPER_BASE   = 17'h02000;

  // ----------------------------------------------------------------
  // Fault pin stretch and clock monitor timing
  // ----------------------------------------------------------------
  localparam int unsigned STRETCH_CYC  = 16;
  localparam logic [4:0]  STRETCH_LAST = 5'(STRETCH_CYC - 1);
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned CM_LIMIT_US  = 1000;
  localparam int unsigned CM_LIMIT_CYC = CM_LIMIT_US * CLK_MHZ;
  localparam int unsigned CM_GOOD_TICKS = 16;
  localparam int unsigned GAP_W        = 24;

endpackage

/* core/fault_stretch.sv */
// Fault pin driver: pulls low, stretches after the pin is seen low.
`timescale 1ns/100ps
`default_nettype none

module fault_stretch
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic trigger,
  input  wire logic pin_low,
  output logic      drive,
  output logic      busy,
  output logic      done
);

  typedef enum logic [1:0] {ST_IDLE, ST_PULL, ST_HOLD, ST_WAIT} fs_state_t;

  fs_state_t  state;
  fs_state_t  next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // The hold count starts only once the pin is seen low, so a slow
  // external edge still gets the full stretch.
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE:
        if (trigger)
          next_state = ST_PULL;
      ST_PULL:
        if (pin_low)
        begin
          next_state = ST_HOLD;
          next_cnt   = 5'h00;
        end
      ST_HOLD:
        if (cnt == wdog_pkg::STRETCH_LAST)
          next_state = ST_WAIT;
        else
          next_cnt = cnt + 5'h01;
      default:
        if (!pin_low)
          next_state = ST_IDLE;
    endcase
  end

  // Registers only.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      cnt   <= 5'h00;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign drive = (state == ST_PULL) || (state == ST_HOLD);
  assign busy  = (state != ST_IDLE);
  assign done  = (state == ST_WAIT) && !pin_low;

  sequence s_seen_low;
    (state == ST_PULL) && pin_low;
  endsequence

  a_stretch_len: assert property (@(posedge core_clk) disable iff (!resetn)
    s_seen_low |-> ##16 drive ##1 !drive)
    else $error("fault stretch length wrong");

endmodule // fault_stretch

`default_nettype wire

/* core/clock_check.sv */
// Clock monitor: flags a missing or very slow instruction clock tick.
`timescale 1ns/100ps
`default_nettype none

module clock_check
#(
  parameter int unsigned LIMIT_CYC = wdog_pkg::CM_LIMIT_CYC
)
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic instr_tick,
  output logic      cm_fault
);

  logic [23:0] gap;
  logic [23:0] next_gap;
  logic [4:0]  good;
  logic [4:0]  next_good;
  logic        err;
  logic        next_err;

  // ----------------------------------------------------------------
  // Gap measure
  // ----------------------------------------------------------------
  // The limit sits far between the fast and slow bounds, so core
  // clock tolerance never matters. Halt stops ticks and so flags.
  always_comb
  begin
    next_gap  = gap;
    next_good = good;
    next_err  = err;
    if (!enable)
    begin
      next_gap  = 24'h000000;
      next_good = 5'h00;
      next_err  = 1'b0;
    end
    else if (instr_tick)
    begin
      next_gap = 24'h000000;
      if (err && (good == 5'(wdog_pkg::CM_GOOD_TICKS - 1)))
        next_err = 1'b0;
      else if (err)
        next_good = good + 5'h01;
    end
    else if (gap == 24'(LIMIT_CYC - 1))
    begin
      next_err  = 1'b1;
      next_good = 5'h00;
    end
    else
      next_gap = gap + 24'h000001;
  end

  // Registers only; the monitor starts idle out of reset.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap  <= 24'h000000;
      good <= 5'h00;
      err  <= 1'b0;
    end
    else
    begin
      gap  <= next_gap;
      good <= next_good;
      err  <= next_err;
    end
  end

  // Gated by the enable so that switching the monitor off frees the
  // pin at once rather than one cycle late.
  assign cm_fault = err && enable;

  a_cm_timeout: assert property (@(posedge core_clk) disable iff (!resetn)
    (enable && !instr_tick && gap == 24'(LIMIT_CYC - 1)) |=> cm_fault)
    else $error("clock monitor missed timeout");

endmodule // clock_check

`default_nettype wire

/* core/windowed_watchdog_clock_monitor.sv */
// Windowed watchdog with clock monitor and shared fault pin.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Service before 2048 ticks is an error.
// - Top two bits pick 8k-64k upper bound.
// - Bits five to one must hold key.
// - Bit zero enables the clock monitor.
// - After reset: largest window, monitor on.
// - Both detectors inactive during reset.
// - First keyed write loads settings, then locked.
// - Later writes must match all fields.
// - Watchdog active only when option bit clear.
// - Stretch fault low 16 cycles after low.
// - Service during active fault is ignored.
// - Monitor holds fault until clock recovers.
// - Flag below 10 Hz, never above 5 kHz.
// - Key field reads back as zeros.
// - Watchdog frozen during halt and idle.
// - Monitor stays active in halt and idle.
// - Halt exit restarts window with lower check.
// - Idle exit performs a hardware service.
// - Boot entry services, suppresses lower check.
// - Boot return services, restores lower check.
// - First service may precede 2048 ticks.
module windowed_watchdog_clock_monitor
#(
  parameter int unsigned CM_LIMIT_CYC = wdog_pkg::CM_LIMIT_CYC
)
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       idle_tick,
  input  wire logic       instr_tick,
  input  wire logic       wd_option_bit,
  input  wire logic       halt_mode,
  input  wire logic       idle_mode,
  input  wire logic       boot_rom_active,
  input  wire logic       svc_wr,
  input  wire logic [7:0] svc_wdata,
  output logic      [7:0] svc_rdata,
  input  wire logic       fault_pin_in,
  output logic            fault_pin_out,
  output logic            fault_pin_oe
);

  logic [16:0] count;
  logic [16:0] next_count;
  logic [1:0]  sel;
  logic [1:0]  next_sel;
  logic        cm_en;
  logic        next_cm_en;
  logic        configured;
  logic        next_configured;
  logic        lower_en;
  logic        next_lower_en;
  logic [7:0]  next_rdata;
  logic        opt_taken;
  logic        wd_run;
  logic        next_wd_run;
  logic        halt_q;
  logic        idle_q;
  logic        boot_q;
  logic        pin_s1;
  logic        pin_s2;
  logic        pin_low;
  logic        wd_error;
  logic        good_service;
  logic        key_ok;
  logic        full_ok;
  logic [16:0] upper_last;
  logic        low_pwr;
  logic        exit_halt;
  logic        exit_idle;
  logic        boot_enter;
  logic        boot_exit;
  logic        fault_drive;
  logic        fault_busy;
  logic        fault_done;
  logic        cm_fault;
  logic        cm_active;

  // ----------------------------------------------------------------
  // Pin synchroniser and mode edges
  // ----------------------------------------------------------------
  // The pin level is external, so it passes two flops first.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      halt_q <= 1'b0;
      idle_q <= 1'b0;
      boot_q <= 1'b0;
    end
    else
    begin
      pin_s1 <= fault_pin_in;
      pin_s2 <= pin_s1;
      halt_q <= halt_mode;
      idle_q <= idle_mode;
      boot_q <= boot_rom_active;
    end
  end

  assign pin_low    = !pin_s2;
  assign low_pwr    = halt_mode || idle_mode;
  assign exit_halt  = halt_q && !halt_mode;
  assign exit_idle  = idle_q && !idle_mode;
  assign boot_enter = boot_rom_active && !boot_q;
  assign boot_exit  = boot_q && !boot_rom_active;

  // ----------------------------------------------------------------
  // Service decode
  // ----------------------------------------------------------------
  // Upper bound doubles per select step from the 8k base.
  assign upper_last = (wdog_pkg::UPPER_BASE << sel) - 17'h00001;
  assign key_ok     = (svc_wdata[wdog_pkg::KEY_MSB:wdog_pkg::KEY_LSB]
                       == wdog_pkg::SVC_KEY);
  assign full_ok    = key_ok
                      && (svc_wdata[wdog_pkg::SEL_MSB:wdog_pkg::SEL_LSB] == sel)
                      && (svc_wdata[wdog_pkg::CM_BIT] == cm_en);

  // ----------------------------------------------------------------
  // Window counter and service register
  // ----------------------------------------------------------------
  // Mode transitions outrank software writes, since the hardware
  // service that they perform must not be turned into an error.
  always_comb
  begin
    next_count      = count;
    next_sel        = sel;
    next_cm_en      = cm_en;
    next_configured = configured;
    next_lower_en   = lower_en;
    next_wd_run     = wd_run;
    wd_error        = 1'b0;
    good_service    = 1'b0;
    if (!opt_taken)
      next_wd_run = !wd_option_bit;
    if (!wd_run)
      next_count = 17'h00000;
    else if (fault_busy)
      next_count = 17'h00000;
    else if (exit_halt || exit_idle)
    begin
      next_count    = 17'h00000;
      next_lower_en = !boot_rom_active;
    end
    else if (boot_enter)
    begin
      next_count    = 17'h00000;
      next_lower_en = 1'b0;
    end
    else if (boot_exit)
    begin
      next_count    = 17'h00000;
      next_lower_en = 1'b1;
    end
    else if (low_pwr)
      next_count = count;
    else if (svc_wr && !configured)
    begin
      if (key_ok)
      begin
        next_sel        = svc_wdata[wdog_pkg::SEL_MSB:wdog_pkg::SEL_LSB];
        next_cm_en      = svc_wdata[wdog_pkg::CM_BIT];
        next_configured = 1'b1;
        next_lower_en   = !boot_rom_active;
        next_count      = 17'h00000;
        good_service    = 1'b1;
      end
      else
        wd_error = 1'b1;
    end
    else if (svc_wr)
    begin
      if (!full_ok)
        wd_error = 1'b1;
      else if (lower_en && (count < wdog_pkg::LOWER_LIMIT))
        wd_error = 1'b1;
      else
      begin
        next_count   = 17'h00000;
        good_service = 1'b1;
      end
    end
    else if (idle_tick)
    begin
      if (count >= upper_last)
        wd_error = 1'b1;
      else
        next_count = count + 17'h00001;
    end
    next_rdata = {next_sel, wdog_pkg::KEY_READ, next_cm_en};
  end

  // Registers only; reset arms the largest window with monitor on.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count      <= 17'h00000;
      sel        <= wdog_pkg::SEL_RESET;
      cm_en      <= wdog_pkg::CM_RESET;
      configured <= 1'b0;
      lower_en   <= 1'b0;
      svc_rdata  <= {wdog_pkg::SEL_RESET, wdog_pkg::KEY_READ, wdog_pkg::CM_RESET};
      opt_taken  <= 1'b0;
      wd_run     <= 1'b0;
    end
    else
    begin
      count      <= next_count;
      sel        <= next_sel;
      cm_en      <= next_cm_en;
      configured <= next_configured;
      lower_en   <= next_lower_en;
      svc_rdata  <= next_rdata;
      opt_taken  <= 1'b1;
      wd_run     <= next_wd_run;
    end
  end

  // ----------------------------------------------------------------
  // Error sources and fault pin
  // ----------------------------------------------------------------
  // The monitor keeps running through halt and idle on purpose.
  assign cm_active = wd_run && cm_en;

  fault_stretch u_stretch
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .trigger  (wd_error),
    .pin_low  (pin_low),
    .drive    (fault_drive),
    .busy     (fault_busy),
    .done     (fault_done)
  );

  clock_check #(.LIMIT_CYC(CM_LIMIT_CYC)) u_clock
  (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .enable     (cm_active),
    .instr_tick (instr_tick),
    .cm_fault   (cm_fault)
  );

  // Open-drain: the pin only ever sinks; the weak pull-up is outside.
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe  = wd_run && (fault_drive || cm_fault);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_valid_early;
    svc_wr && configured && full_ok && lower_en && wd_run && !fault_busy
    && !low_pwr && !exit_halt && !exit_idle && !boot_enter && !boot_exit
    && (count < wdog_pkg::LOWER_LIMIT);
  endsequence

  sequence s_plain_write;
    svc_wr && wd_run && !fault_busy && !low_pwr && !exit_halt
    && !exit_idle && !boot_enter && !boot_exit;
  endsequence

  a_lower_bound: assert property (@(posedge core_clk) disable iff (!resetn)
    s_valid_early |-> wd_error ##1 fault_busy)
    else $error("early service not flagged");

  a_upper_expire: assert property (@(posedge core_clk) disable iff (!resetn)
    (wd_run && !fault_busy && !low_pwr && !svc_wr && !exit_halt && !exit_idle
     && !boot_enter && !boot_exit && idle_tick && (count >= upper_last))
    |=> fault_busy)
    else $error("upper bound not flagged");

  a_key_check: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_plain_write and !key_ok) |-> wd_error)
    else $error("bad key accepted");

  a_cm_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    (!cm_en && !fault_drive) |-> !fault_pin_oe)
    else $error("monitor drives while disabled");

  a_reset_arm: assert property (@(posedge core_clk) disable iff (!resetn)
    !configured |-> (sel == wdog_pkg::SEL_RESET) && cm_en)
    else $error("reset arming wrong");

  a_cfg_lock: assert property (@(posedge core_clk) disable iff (!resetn)
    configured |=> configured && $stable(sel) && $stable(cm_en))
    else $error("settings changed after lock");

  a_svc_restart: assert property (@(posedge core_clk) disable iff (!resetn)
    good_service |=> (count == 17'h00000) ##1 !fault_busy)
    else $error("service did not restart window");

  a_busy_ignore: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_busy |-> !good_service && (next_count == 17'h00000))
    else $error("service taken during fault");

  a_lowpwr_freeze: assert property (@(posedge core_clk) disable iff (!resetn)
    (low_pwr && !exit_halt && !exit_idle && !boot_enter && !boot_exit)
    |-> !wd_error)
    else $error("watchdog ran in low power");

  a_idle_exit: assert property (@(posedge core_clk) disable iff (!resetn)
    (exit_idle && wd_run && !fault_busy) |=> (count == 17'h00000))
    else $error("idle exit did not service");

  a_boot_entry: assert property (@(posedge core_clk) disable iff (!resetn)
    (boot_enter && wd_run && !fault_busy && !exit_halt && !exit_idle)
    |=> !lower_en && (count == 17'h00000))
    else $error("boot entry mishandled");

  a_fault_or: assert property (@(posedge core_clk) disable iff (!resetn)
    (wd_run && (cm_fault || fault_drive)) |-> fault_pin_oe)
    else $error("fault pin not driven");

  a_option_off: assert property (@(posedge core_clk) disable iff (!resetn)
    !wd_run |-> !fault_pin_oe && !fault_busy ##1 !fault_busy)
    else $error("pin driven with watchdog off");

  a_pin_restart: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_done |=> !fault_busy && (count == 17'h00000))
    else $error("window not restarted after fault");

endmodule // windowed_watchdog_clock_monitor

`default_nettype wire

/* tb/fault_line_model.sv */
// Fault line model: weak pull-up, slow falling edge.
`timescale 1ns/100ps
`default_nettype none

module fault_line_model
#(
  parameter int unsigned FALL_CYC = 2
)
(
  input  wire logic core_clk,
  input  wire logic sink_oe,
  output logic      pin
);
  int unsigned held = 0;

  // ----------------
  // Line level
  // ----------------
  // The pull-up wins whenever nobody sinks; a loaded line falls late.
  always @(posedge core_clk)
  begin
    held = sink_oe ? held + 1 : 0;
    pin <= !(sink_oe && held > FALL_CYC);
  end
endmodule // fault_line_model

`default_nettype wire

/* tb/windowed_watchdog_clock_monitor_test.sv */
// Testbench for the windowed watchdog and clock monitor.
`timescale 1ns/100ps
`default_nettype none

module windowed_watchdog_clock_monitor_test;
  logic        core_clk;
  logic        resetn;
  logic        idle_tick;
  logic        instr_tick = 1'b0;
  logic        wd_option_bit;
  logic        halt_mode;
  logic        idle_mode;
  logic        boot_rom_active;
  logic        svc_wr;
  logic [7:0]  svc_wdata;
  logic [7:0]  svc_rdata;
  logic        pin;
  logic        oe;
  logic        pin_out;
  logic        tick_on;
  logic [31:0] rng;
  logic [7:0]  cfg;
  bit          cfg_done;
  bit          lower_on;
  int          err_total;
  int          n_checks;
  int          cyc = 0;
  int          stamp;
  int          i;

  windowed_watchdog_clock_monitor #(.CM_LIMIT_CYC(200)) windowed_watchdog_clock_monitor_i
  (
    .core_clk        (core_clk),
    .resetn          (resetn),
    .idle_tick       (idle_tick),
    .instr_tick      (instr_tick),
    .wd_option_bit   (wd_option_bit),
    .halt_mode       (halt_mode),
    .idle_mode       (idle_mode),
    .boot_rom_active (boot_rom_active),
    .svc_wr          (svc_wr),
    .svc_wdata       (svc_wdata),
    .svc_rdata       (svc_rdata),
    .fault_pin_in    (pin),
    .fault_pin_out   (pin_out),
    .fault_pin_oe    (oe)
  );

  fault_line_model fault_line_model_i
  (
    .core_clk (core_clk),
    .sink_oe  (oe),
    .pin      (pin)
  );

  // ----------------
  // Clock, ticks and model time
  // ----------------
  // The model counts window age as cycles since its last restart stamp.
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    instr_tick <= tick_on && !instr_tick;
  end

  // ----------------
  // Checking helpers
  // ----------------
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic chk_oe(input logic e);
    #1;
    check({7'h00, oe}, {7'h00, e});
  endtask

  task automatic give_verdict;
    $display("checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // ----------------
  // Stimulus tasks
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic pulse(input logic [7:0] d);
    @(posedge core_clk);
    svc_wr <= 1'b1;
    svc_wdata <= d;
    @(posedge core_clk);
    svc_wr <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  // Predicts the outcome of one service write from the model state.
  task automatic svc(input logic [7:0] d);
    logic bad;
    bad = d[5:1] !== wdog_pkg::SVC_KEY;
    if (cfg_done)
      bad = bad || d !== cfg || (lower_on && cyc - stamp < 2048);
    pulse(d);
    chk_oe(bad);
    if (!bad)
    begin
      stamp = cyc;
      if (!cfg_done)
        cfg = d;
      cfg_done = 1;
      lower_on = !boot_rom_active;
    end
  endtask

  task automatic wait_oe(input int lim);
    for (int k = 0; k < lim && oe !== 1'b1; k++)
      @(posedge core_clk);
    #1;
  endtask

  // Waits out a fault; the stretch is measured only for watchdog faults.
  task automatic recover(input bit wd);
    int n;
    n = 0;
    for (int k = 0; k < 400 && oe === 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
      if (!pin && oe)
        n++;
    end
    chk_oe(1'b0);
    check({7'h00, pin_out}, 8'h00);
    if (wd)
      check({7'h00, n >= 16 && n <= 32}, 8'h01);
    tick(5);
    stamp = cyc;
  endtask

  task automatic do_reset(input logic opt);
    @(posedge core_clk);
    resetn <= 1'b0;
    wd_option_bit <= opt;
    tick(4);
    #1;
    check(svc_rdata, 8'hc1);
    chk_oe(1'b0);
    @(posedge core_clk);
    resetn <= 1'b1;
    cfg_done = 0;
    lower_on = 0;
    tick(2);
    stamp = cyc;
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    resetn = 1'b0;
    idle_tick = 1'b1;
    wd_option_bit = 1'b0;
    halt_mode = 1'b0;
    idle_mode = 1'b0;
    boot_rom_active = 1'b0;
    svc_wr = 1'b0;
    svc_wdata = 8'h00;
    tick_on = 1'b1;
    rng = 32'h70dd;
    err_total = 0;
    n_checks = 0;
    do_reset(1'b0);
    rng = xs(rng);
    svc({2'b00, rng[4:0] ^ 5'h13, 1'b1});
    recover(1);
    svc(8'h19);
    check(svc_rdata, 8'h01);
    tick(2100);
    svc(8'h19);
    tick(100);
    svc(8'h19);
    pulse(8'h19);
    recover(1);
    tick(100);
    chk_oe(1'b0);
    for (i = 0; i < 3; i++)
    begin
      rng = xs(rng);
      tick(2100);
      svc(i == 0 ? 8'hd9 : i == 1 ? 8'h18 : {2'b00, rng[4:0] | 5'h10, 1'b1});
      recover(1);
    end
    tick(2100);
    svc(8'h19);
    tick(8150);
    chk_oe(1'b0);
    wait_oe(100);
    chk_oe(1'b1);
    recover(1);
    tick(2100);
    svc(8'h19);
    tick(3000);
    idle_mode <= 1'b1;
    tick(3000);
    idle_mode <= 1'b0;
    stamp = cyc;
    tick(7000);
    svc(8'h19);
    tick(7000);
    boot_rom_active <= 1'b1;
    lower_on = 0;
    tick(100);
    svc(8'h19);
    tick(3000);
    boot_rom_active <= 1'b0;
    stamp = cyc;
    lower_on = 1;
    tick(6000);
    svc(8'h19);
    tick(2100);
    svc(8'h19);
    tick(1);
    halt_mode <= 1'b1;
    tick_on <= 1'b0;
    wait_oe(260);
    chk_oe(1'b1);
    tick(300);
    chk_oe(1'b1);
    tick(1);
    halt_mode <= 1'b0;
    tick_on <= 1'b1;
    recover(0);
    tick(100);
    svc(8'h19);
    recover(1);
    do_reset(1'b0);
    svc(8'h58);
    check(svc_rdata, 8'h40);
    tick_on <= 1'b0;
    tick(400);
    chk_oe(1'b0);
    tick_on <= 1'b1;
    tick(15900);
    chk_oe(1'b0);
    wait_oe(200);
    chk_oe(1'b1);
    recover(1);
    do_reset(1'b1);
    tick_on <= 1'b0;
    pulse(8'h00);
    tick(400);
    chk_oe(1'b0);
    give_verdict();
  end

  // ----------------
  // Watchdog
  // ----------------
  // The full sequence needs about 70000 cycles; this leaves a margin.
  initial
  begin
    #1_000_000;
    err_total++;
    give_verdict();
  end
endmodule // windowed_watchdog_clock_monitor_test

`default_nettype wire
